// File: hw/ltm_top.sv
// Lockable timeout monitor: counter, lock, reset request and register file
`timescale 1ns/1ps
module ltm_top (
	input wire logic aclk, // System clock, 200 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic lfo_clk, // Low-frequency oscillator, asynchronous
	input wire logic [7:0] s_axil_awaddr, // Write address
	input wire logic s_axil_awvalid, // Write address valid
	output logic s_axil_awready, // Write address ready
	input wire logic [31:0] s_axil_wdata, // Write data
	input wire logic [3:0] s_axil_wstrb, // Write byte strobes
	input wire logic s_axil_wvalid, // Write data valid
	output logic s_axil_wready, // Write data ready
	output logic [1:0] s_axil_bresp, // Write response
	output logic s_axil_bvalid, // Write response valid
	input wire logic s_axil_bready, // Write response ready
	input wire logic [7:0] s_axil_araddr, // Read address
	input wire logic s_axil_arvalid, // Read address valid
	output logic s_axil_arready, // Read address ready
	output logic [31:0] s_axil_rdata, // Read data
	output logic [1:0] s_axil_rresp, // Read response
	output logic s_axil_rvalid, // Read data valid
	input wire logic s_axil_rready, // Read data ready
	output logic sys_rst_req, // System reset request, held until reset
	output logic ext_rst_oe_n, // Reset pin output enable, never asserted
	output logic irq // Interrupt, level
);
	ltm_pkg::ltm_ctrl_t ctrl, next_ctrl;
	logic [ltm_pkg::CNT_W-1:0] count, next_count;
	logic rst_req, next_rst_req;
	logic [ltm_pkg::EV_W-1:0] status, next_status;
	logic [ltm_pkg::EV_W-1:0] mask, next_mask;
	logic irq_q, next_irq;
	logic tick;
	ltm_pkg::ltm_wr_t wr;
	logic wr_valid;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic [ltm_pkg::CNT_W-1:0] last;
	logic wr_lane0;
	logic warn_ev;
	logic reject_ev;

	ltm_lfo_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.lfo_clk(lfo_clk),
		.tick(tick)
	);

	ltm_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.wr(wr),
		.wr_valid(wr_valid),
		.rd_data(rd_data),
		.rd_addr(rd_addr)
	);

	assign last = ltm_pkg::last_tick(ctrl.sel);
	// All fields live in byte 0; other lanes alone change nothing
	assign wr_lane0 = wr_valid && wr.strb[0];
	assign sys_rst_req = rst_req;
	// Overflow reset stays internal; the pin driver is never enabled
	assign ext_rst_oe_n = 1'b1; // R8
	assign irq = irq_q;

	always_comb begin
		rd_data = 32'h00000000;
		if (rd_addr == ltm_pkg::OFF_CTRL) begin
			rd_data[ltm_pkg::CTRL_EN_BIT] = ctrl.en;
			rd_data[ltm_pkg::CTRL_SEL_LSB +: ltm_pkg::SEL_W] = ctrl.sel;
			rd_data[ltm_pkg::CTRL_LOCK_BIT] = ctrl.lock;
		end else if (rd_addr == ltm_pkg::OFF_STATUS) begin
			rd_data[ltm_pkg::EV_W-1:0] = status;
		end else if (rd_addr == ltm_pkg::OFF_MASK) begin
			rd_data[ltm_pkg::EV_W-1:0] = mask;
		end else if (rd_addr == ltm_pkg::OFF_COUNT) begin
			rd_data[ltm_pkg::CNT_W-1:0] = count;
		end
	end

	always_comb begin
		next_ctrl = ctrl;
		next_count = count;
		next_rst_req = rst_req;
		next_status = status;
		next_mask = mask;
		warn_ev = 1'b0;
		reject_ev = 1'b0;

		// Counting on oscillator edges only; stops once reset is requested
		if (ctrl.en && !rst_req && tick) begin // R1
			if (count == last) begin
				next_rst_req = 1'b1; // R2
			end else begin
				next_count = count + 14'h0001;
			end
			if (count == (last >> 1)) begin
				warn_ev = 1'b1;
			end
		end

		if (wr_lane0 && wr.addr == ltm_pkg::OFF_CTRL) begin
			if (ctrl.lock) begin // R7
				// Locked: every field frozen, a clear of enable is flagged
				if (!wr.data[ltm_pkg::CTRL_EN_BIT]) begin // R6
					reject_ev = 1'b1;
				end
			end else begin
				next_ctrl.en = wr.data[ltm_pkg::CTRL_EN_BIT]; // R5
				next_ctrl.sel = wr.data[ltm_pkg::CTRL_SEL_LSB +: ltm_pkg::SEL_W]; // R7
				next_ctrl.lock = wr.data[ltm_pkg::CTRL_LOCK_BIT];
				if (wr.data[ltm_pkg::CTRL_LOCK_BIT]) begin
					next_ctrl.en = 1'b1; // R6
				end
			end
		end

		// Restart beats a same-cycle tick on the count, but a tick at the last count still raises the reset request
		if (wr_lane0 && wr.addr == ltm_pkg::OFF_RESTART && wr.data[ltm_pkg::RESTART_BIT]) begin
			next_count = ltm_pkg::COUNT_RST; // R9
		end
		if (!ctrl.en) begin
			next_count = ltm_pkg::COUNT_RST; // R5
		end

		if (wr_lane0 && wr.addr == ltm_pkg::OFF_MASK) begin
			next_mask = wr.data[ltm_pkg::EV_W-1:0];
		end
		if (wr_lane0 && wr.addr == ltm_pkg::OFF_STATUS) begin
			next_status = status & ~wr.data[ltm_pkg::EV_W-1:0];
		end
		// Set after clear: an event in the clearing cycle is kept
		next_status[ltm_pkg::EV_WARN_BIT] = next_status[ltm_pkg::EV_WARN_BIT] | warn_ev;
		next_status[ltm_pkg::EV_REJECT_BIT] = next_status[ltm_pkg::EV_REJECT_BIT] | reject_ev;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl.en <= ltm_pkg::CTRL_EN_RST; // R4
			ctrl.sel <= ltm_pkg::CTRL_SEL_RST; // R4
			ctrl.lock <= ltm_pkg::CTRL_LOCK_RST; // R6
			count <= ltm_pkg::COUNT_RST;
			rst_req <= 1'b0;
			status <= ltm_pkg::STATUS_RST;
			mask <= ltm_pkg::MASK_RST;
			irq_q <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			count <= next_count;
			rst_req <= next_rst_req;
			status <= next_status;
			mask <= next_mask;
			irq_q <= next_irq;
		end
	end
endmodule

// File: hw/ltm_pkg.sv
// Constants, types and decode helpers for the lockable timeout monitor
// How it works
// R1 - Count advances on low-frequency oscillator ticks
// R2 - Overflow requests a whole-chip system reset
// R3 - Software restarts before the timeout expires
// R4 - Reset leaves it enabled with longest timeout
// R5 - Unlocked, software may disable counting entirely
// R6 - Once locked, disable attempts ignored until reset
// R7 - Once locked, configuration changes also ignored
// R8 - Watchdog reset never drives the reset pin
// R9 - Restart clears count, full interval begins again
package ltm_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 14;
	localparam int SEL_W = 3;
	localparam int EV_W = 2;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RESTART = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0C;
	localparam logic [7:0] OFF_COUNT = 8'h10;

	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int CTRL_LOCK_BIT = 4;
	localparam int RESTART_BIT = 0;
	localparam int EV_WARN_BIT = 0;
	localparam int EV_REJECT_BIT = 1;

	// Reset values
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [SEL_W-1:0] CTRL_SEL_RST = 3'h7;
	localparam logic CTRL_LOCK_RST = 1'b0;
	localparam logic [EV_W-1:0] STATUS_RST = 2'h0;
	localparam logic [EV_W-1:0] MASK_RST = 2'h0;
	localparam logic [CNT_W-1:0] COUNT_RST = 14'h0000;

	// Timeout is 2^(sel + base) oscillator ticks
	localparam logic [3:0] TICK_SHIFT_BASE = 4'h6;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic lock;
		logic [SEL_W-1:0] sel;
		logic en;
	} ltm_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [3:0] strb;
	} ltm_wr_t;

	function automatic logic [CNT_W-1:0] last_tick(input logic [SEL_W-1:0] sel);
		logic [3:0] sh;
		sh = {1'b0, sel} + TICK_SHIFT_BASE;
		return (14'h0001 << sh) - 14'h0001;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		return (addr == OFF_CTRL) || (addr == OFF_RESTART) || (addr == OFF_STATUS) ||
			(addr == OFF_MASK) || (addr == OFF_COUNT);
	endfunction

endpackage

// File: hw/ltm_lfo_edge.sv
// Synchroniser and rising-edge detector for the low-frequency oscillator
`timescale 1ns/1ps
module ltm_lfo_edge (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic lfo_clk, // Low-frequency oscillator, asynchronous
	output logic tick // One-cycle pulse per oscillator rising edge
);
	logic [2:0] sync;
	logic [2:0] next_sync;

	always_comb begin
		next_sync = {sync[1:0], lfo_clk};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync <= 3'h0;
		end else begin
			sync <= next_sync;
		end
	end

	// Stage 0 feeds stage 1 only; the edge looks at stages 1 and 2
	assign tick = sync[1] & ~sync[2]; // R1
endmodule

// File: hw/ltm_axil.sv
// AXI4-Lite slave front end turning bus traffic into register strobes
`timescale 1ns/1ps
module ltm_axil (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axil_awaddr, // Write address
	input wire logic s_axil_awvalid, // Write address valid
	output logic s_axil_awready, // Write address ready
	input wire logic [31:0] s_axil_wdata, // Write data
	input wire logic [3:0] s_axil_wstrb, // Write byte strobes
	input wire logic s_axil_wvalid, // Write data valid
	output logic s_axil_wready, // Write data ready
	output logic [1:0] s_axil_bresp, // Write response
	output logic s_axil_bvalid, // Write response valid
	input wire logic s_axil_bready, // Write response ready
	input wire logic [7:0] s_axil_araddr, // Read address
	input wire logic s_axil_arvalid, // Read address valid
	output logic s_axil_arready, // Read address ready
	output logic [31:0] s_axil_rdata, // Read data
	output logic [1:0] s_axil_rresp, // Read response
	output logic s_axil_rvalid, // Read data valid
	input wire logic s_axil_rready, // Read data ready
	output ltm_pkg::ltm_wr_t wr, // Write to commit
	output logic wr_valid, // Commit strobe, one cycle
	input wire logic [31:0] rd_data, // Read word for rd_addr
	output logic [7:0] rd_addr // Address being read
);
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;

	assign s_axil_awready = !aw_held;
	assign s_axil_wready = !w_held;
	assign s_axil_arready = !rvalid;
	assign s_axil_bvalid = bvalid;
	assign s_axil_bresp = bresp;
	assign s_axil_rvalid = rvalid;
	assign s_axil_rdata = rdata;
	assign s_axil_rresp = rresp;
	assign rd_addr = s_axil_araddr;
	// Commit only when the previous response has gone, so one write is in flight
	assign wr_valid = aw_held && w_held && !bvalid;
	assign wr = '{addr: aw_addr, data: w_data, strb: w_strb};

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axil_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axil_awaddr;
		end
		if (s_axil_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axil_wdata;
			next_w_strb = s_axil_wstrb;
		end
		if (bvalid && s_axil_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_valid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = ltm_pkg::is_mapped(aw_addr) ? ltm_pkg::RESP_OKAY : ltm_pkg::RESP_SLVERR;
		end
		if (rvalid && s_axil_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axil_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = rd_data;
			next_rresp = ltm_pkg::is_mapped(s_axil_araddr) ? ltm_pkg::RESP_OKAY :
				ltm_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
endmodule

// File: verification/ltm_asserts.sv
// Port-level checks for the lockable timeout monitor
`timescale 1ns/1ps
module ltm_asserts (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axil_awvalid, // Watched
	input wire logic s_axil_awready, // Watched
	input wire logic s_axil_wvalid, // Watched
	input wire logic s_axil_wready, // Watched
	input wire logic [1:0] s_axil_bresp, // Watched
	input wire logic s_axil_bvalid, // Watched
	input wire logic s_axil_bready, // Watched
	input wire logic s_axil_arvalid, // Watched
	input wire logic s_axil_arready, // Watched
	input wire logic [31:0] s_axil_rdata, // Watched
	input wire logic s_axil_rvalid, // Watched
	input wire logic s_axil_rready, // Watched
	input wire logic sys_rst_req, // Watched
	input wire logic ext_rst_oe_n, // Watched
	input wire logic irq // Watched
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_take;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence b_due;
		##2 s_axil_bvalid;
	endsequence

	pin_idle_a: assert property (ext_rst_oe_n)
		else $error("reset pin enable asserted");
	req_held_a: assert property (sys_rst_req |=> sys_rst_req)
		else $error("reset request dropped before reset");
	reset_clean_a: assert property ($rose(aresetn) |-> !sys_rst_req && !irq && !s_axil_bvalid)
		else $error("outputs not idle after reset");
	wr_answer_a: assert property (wr_take |-> b_due)
		else $error("write response late");
	rd_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("read data late");
	b_hold_a: assert property (s_axil_bvalid && !s_axil_bready
		|=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write response not held");
	r_hold_a: assert property (s_axil_rvalid && !s_axil_rready
		|=> s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data not held");
	ar_gate_a: assert property (s_axil_arready == !s_axil_rvalid)
		else $error("read address ready wrong");
endmodule

// File: verification/ltm_top_bench.sv
// Self-checking bench for the lockable timeout monitor
`timescale 1ns/1ps
module ltm_top_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic lfo_clk = 1'b0;
	logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
	logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rdat;
	logic [3:0] s_axil_wstrb = 4'h0;
	logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
	logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
	logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0] s_axil_bresp, s_axil_rresp, resp;
	logic sys_rst_req, ext_rst_oe_n, irq;
	int errors = 0;
	int checks = 0;

	ltm_top u_ltm_top (.*);

	always #2.5 aclk = ~aclk;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic conclude;
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		logic ta, tw;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_wstrb <= s;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axil_awvalid && s_axil_awready;
			tw = s_axil_wvalid && s_axil_wready;
			@(posedge aclk);
			if (ta) s_axil_awvalid <= 1'b0;
			if (tw) s_axil_wvalid <= 1'b0;
		end while (s_axil_awvalid && !ta || s_axil_wvalid && !tw);
		do @(negedge aclk); while (!s_axil_bvalid);
		// Late ready so the response has to stand through one stalled cycle
		@(posedge aclk);
		s_axil_bready <= 1'b1;
		@(negedge aclk);
		resp = s_axil_bresp;
		@(posedge aclk);
		s_axil_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		do @(negedge aclk); while (!s_axil_arready);
		@(posedge aclk);
		s_axil_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axil_rvalid);
		// Late ready so the read data has to stand through one stalled cycle
		@(posedge aclk);
		s_axil_rready <= 1'b1;
		@(negedge aclk);
		rdat = s_axil_rdata;
		resp = s_axil_rresp;
		@(posedge aclk);
		s_axil_rready <= 1'b0;
	endtask

	// Slow oscillator; the tail lets the synchronised last tick land
	task automatic ticks(input int n);
		repeat (n) begin
			repeat (5) @(posedge aclk);
			lfo_clk <= 1'b1;
			repeat (5) @(posedge aclk);
			lfo_clk <= 1'b0;
		end
		repeat (6) @(posedge aclk);
	endtask

	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task automatic s_reset;
		rd(ltm_pkg::OFF_CTRL);
		chk(rdat, 32'h0F);
		chk(sys_rst_req, 1'b0);
		ticks(3);
		rd(ltm_pkg::OFF_COUNT);
		chk(rdat, 32'h03);
	endtask

	task automatic s_timeout;
		wr(ltm_pkg::OFF_CTRL, 32'h01);
		wr(ltm_pkg::OFF_RESTART, 32'h01);
		rd(ltm_pkg::OFF_COUNT);
		chk(rdat, 32'h0);
		ticks(40);
		rd(ltm_pkg::OFF_COUNT);
		chk(rdat, 32'h28);
		rd(ltm_pkg::OFF_STATUS);
		chk(rdat, 32'h01);
		wr(ltm_pkg::OFF_MASK, 32'h01);
		@(negedge aclk);
		chk(irq, 1'b1);
		wr(ltm_pkg::OFF_STATUS, 32'h01);
		@(negedge aclk);
		chk(irq, 1'b0);
		wr(ltm_pkg::OFF_RESTART, 32'h01);
		rd(ltm_pkg::OFF_COUNT);
		chk(rdat, 32'h0);
		ticks(63);
		chk(sys_rst_req, 1'b0);
		ticks(1);
		chk(sys_rst_req, 1'b1);
		chk(ext_rst_oe_n, 1'b1);
	endtask

	task automatic s_disable;
		// Upper lanes only: the enable must survive
		wr(ltm_pkg::OFF_CTRL, 32'h00, 4'hE);
		chk(resp, ltm_pkg::RESP_OKAY);
		rd(ltm_pkg::OFF_CTRL);
		chk(rdat, 32'h0F);
		wr(ltm_pkg::OFF_CTRL, 32'h00);
		ticks(70);
		chk(sys_rst_req, 1'b0);
		rd(ltm_pkg::OFF_COUNT);
		chk(rdat, 32'h0);
	endtask

	task automatic s_lock;
		wr(ltm_pkg::OFF_CTRL, 32'h11);
		wr(ltm_pkg::OFF_CTRL, 32'h0E);
		chk(resp, ltm_pkg::RESP_OKAY);
		rd(ltm_pkg::OFF_CTRL);
		chk(rdat, 32'h11);
		rd(ltm_pkg::OFF_STATUS);
		chk(rdat, 32'h02);
		chk(irq, 1'b0);
		wr(ltm_pkg::OFF_MASK, 32'h02);
		@(negedge aclk);
		chk(irq, 1'b1);
		rd(8'h14);
		chk(resp, ltm_pkg::RESP_SLVERR);
		chk(rdat, 32'h0);
		ticks(64);
		chk(sys_rst_req, 1'b1);
		do_reset;
		rd(ltm_pkg::OFF_CTRL);
		chk(rdat, 32'h0F);
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset;
		s_timeout;
		do_reset;
		s_disable;
		do_reset;
		s_lock;
		conclude;
	end

	// Whole run needs about 3000 cycles
	initial begin
		#100000;
		errors++;
		conclude;
	end
endmodule

bind ltm_top ltm_asserts u_ltm_asserts (.*);
